// file: hdl/clb_pkg.sv
package clb_pkg;
    // Cycle qualifier encodings
    localparam logic MIO_MEMORY = 1'b1;
    localparam logic WR_WRITE = 1'b1;
    // Strap layout and reset values
    localparam int STRAP_W = 4;
    localparam logic [3:0] STRAP_RESET = 4'h0;
    localparam logic [3:0] RAS_IDLE = 4'hF;
    localparam int ADDR_LO = 2;
    localparam int ADDR_HI = 25;
    localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
    // Reset timing
    localparam int RESET_HOLD_NS = 1000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 6;
    localparam int SOFT_RESET_CYC = 2;

    typedef enum logic [1:0] {
        CLB_OWN_CPU,
        CLB_OWN_MASTER,
        CLB_OWN_DMA
    } clb_owner_t;

    typedef enum logic [1:0] {
        CLB_CYC_IO_RD,
        CLB_CYC_IO_WR,
        CLB_CYC_MEM_RD,
        CLB_CYC_MEM_WR
    } clb_cyc_t;
endpackage : clb_pkg

// file: hdl/clb_reset_gen.sv
`timescale 1ns/1ps
module clb_reset_gen
    import clb_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Power state and soft reset request
    input wire logic power_ok_i,
    input wire logic soft_reset_req_i,
    // Reset outputs
    output logic por_active_o,
    output logic processor_hard_reset_o,
    output logic isa_reset_n_o,
    output logic processor_soft_reset_o
);
    logic [CNT_W-1:0] hold_q;
    logic [1:0] soft_q;

    // Power-on reset stays active until power is good for the hold time
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !power_ok_i) begin
            hold_q <= '0;
        end else if (hold_q != CNT_W'(RESET_HOLD_CYC)) begin
            hold_q <= hold_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            por_active_o <= 1'b1;
            processor_hard_reset_o <= 1'b1;
            isa_reset_n_o <= 1'b0;
        end else begin
            por_active_o <= hold_q != CNT_W'(RESET_HOLD_CYC);
            processor_hard_reset_o <= hold_q != CNT_W'(RESET_HOLD_CYC);
            isa_reset_n_o <= hold_q == CNT_W'(RESET_HOLD_CYC);
        end
    end

    // Soft reset pulse, independent of the hard reset
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            soft_q <= '0;
        end else if (soft_reset_req_i && soft_q == '0) begin
            soft_q <= 2'(SOFT_RESET_CYC);
        end else if (soft_q != '0) begin
            soft_q <= soft_q - 1'b1;
        end
    end

    assign processor_soft_reset_o = soft_q != '0;

    property p_isa_follows_por;
        @(posedge clk_i) disable iff (!reset_n_i)
        !por_active_o |-> isa_reset_n_o;
    endproperty
    a_isa_follows_por: assert property (p_isa_follows_por) else $error("isa reset mismatch");

    property p_isa_low_in_por;
        @(posedge clk_i) disable iff (!reset_n_i)
        por_active_o |-> !isa_reset_n_o;
    endproperty
    a_isa_low_in_por: assert property (p_isa_low_in_por) else $error("isa reset not held in por");

    property p_soft_pulse;
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(processor_soft_reset_o) |-> processor_soft_reset_o ##1 processor_soft_reset_o ##1 !processor_soft_reset_o;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset width wrong");
endmodule : clb_reset_gen

// file: hdl/clb_pin_logic.sv
`timescale 1ns/1ps
module clb_pin_logic
    import clb_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic power_ok_i,
    input wire logic soft_reset_req_i,
    // Processor type: high for 486 class, low for 386 class
    input wire logic cpu_is_486_i,
    // Cycle qualifiers
    input wire logic cycle_start_strobe_n_i,
    input wire logic mem_or_io_i,
    input wire logic write_or_read_i,
    output logic cycle_start_o,
    output logic cycle_is_mem_o,
    output logic cycle_is_write_o,
    output clb_cyc_t cycle_type_o,
    // Bus ownership
    input clb_owner_t owner_i,
    // Local address bus 2..25
    input wire logic [ADDR_W-1:0] local_addr_bus_i,
    input wire logic [ADDR_W-1:0] dma_addr_i,
    output logic [ADDR_W-1:0] local_addr_bus_o,
    output logic local_addr_bus_oe_o,
    output logic [ADDR_W-1:0] captured_addr_o,
    // Address bit 26 or coprocessor busy
    input wire logic addr_bit26_or_fpu_busy_i,
    input wire logic dma_addr26_i,
    output logic addr_bit26_or_fpu_busy_o,
    output logic addr_bit26_or_fpu_busy_oe_o,
    output logic captured_addr26_o,
    output logic fpu_busy_o,
    // Clock strap / row strobe pins
    input wire logic [STRAP_W-1:0] clock_freq_strap_i,
    input wire logic [STRAP_W-1:0] row_strobe_n_req_i,
    output logic [STRAP_W-1:0] clock_freq_strap_o,
    output logic [STRAP_W-1:0] clock_freq_strap_oe_o,
    output logic [STRAP_W-1:0] clock_freq_sel_o,
    // Code/data or alter bit
    input wire logic mem_addr_bit9_i,
    input wire logic code_data_or_alter_bit_i,
    input wire logic alter_bit_out_i,
    output logic code_data_or_alter_bit_o,
    output logic code_data_or_alter_bit_oe_o,
    output logic alter_mode_o,
    output logic code_data_o,
    // Resets
    output logic processor_hard_reset_o,
    output logic isa_reset_n_o,
    output logic processor_soft_reset_o
);
    logic por_active;
    logic strobe_q;
    logic [STRAP_W-1:0] strap_q;
    logic alter_q;
    logic strap_done_q;

    function automatic clb_cyc_t clb_decode(input logic mio, input logic wr);
        case ({mio == MIO_MEMORY, wr == WR_WRITE})
            2'b00: clb_decode = CLB_CYC_IO_RD;
            2'b01: clb_decode = CLB_CYC_IO_WR;
            2'b10: clb_decode = CLB_CYC_MEM_RD;
            default: clb_decode = CLB_CYC_MEM_WR;
        endcase
    endfunction : clb_decode

    clb_reset_gen u_reset (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .power_ok_i(power_ok_i),
        .soft_reset_req_i(soft_reset_req_i),
        .por_active_o(por_active),
        .processor_hard_reset_o(processor_hard_reset_o),
        .isa_reset_n_o(isa_reset_n_o),
        .processor_soft_reset_o(processor_soft_reset_o)
    );

    ////////////////////////////////////////////////////////////////
    // Cycle start detection and qualifier decode
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            strobe_q <= 1'b1;
        end else begin
            strobe_q <= cycle_start_strobe_n_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cycle_start_o <= 1'b0;
            cycle_is_mem_o <= 1'b0;
            cycle_is_write_o <= 1'b0;
            cycle_type_o <= CLB_CYC_IO_RD;
            captured_addr_o <= '0;
            captured_addr26_o <= 1'b0;
        end else begin
            cycle_start_o <= strobe_q && !cycle_start_strobe_n_i;
            if (strobe_q && !cycle_start_strobe_n_i) begin
                cycle_is_mem_o <= mem_or_io_i == MIO_MEMORY;
                cycle_is_write_o <= write_or_read_i == WR_WRITE;
                cycle_type_o <= clb_decode(mem_or_io_i, write_or_read_i);
                captured_addr_o <= local_addr_bus_i;
                captured_addr26_o <= cpu_is_486_i && addr_bit26_or_fpu_busy_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Address direction
    always_comb begin
        local_addr_bus_oe_o = owner_i == CLB_OWN_DMA;
        local_addr_bus_o = dma_addr_i;
        addr_bit26_or_fpu_busy_oe_o = cpu_is_486_i && owner_i != CLB_OWN_CPU;
        addr_bit26_or_fpu_busy_o = dma_addr26_i;
        fpu_busy_o = !cpu_is_486_i && !addr_bit26_or_fpu_busy_i;
    end

    ////////////////////////////////////////////////////////////////
    // Straps
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            strap_q <= STRAP_RESET;
            alter_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (por_active) begin
            strap_q <= clock_freq_strap_i;
            alter_q <= !mem_addr_bit9_i;
            strap_done_q <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
        end
    end

    always_comb begin
        clock_freq_sel_o = strap_q;
        alter_mode_o = alter_q;
        clock_freq_strap_oe_o = strap_done_q ? {STRAP_W{1'b1}} : '0;
        clock_freq_strap_o = strap_done_q ? row_strobe_n_req_i : RAS_IDLE;
        code_data_or_alter_bit_oe_o = strap_done_q && alter_q;
        code_data_or_alter_bit_o = alter_bit_out_i;
        code_data_o = !alter_q && code_data_or_alter_bit_i;
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    property p_start_edge;
        @(posedge clk_i) disable iff (!reset_n_i)
        cycle_start_o |-> $past(strobe_q) && !strobe_q;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("start without falling strobe");

    property p_mem_decode;
        @(posedge clk_i) disable iff (!reset_n_i)
        $fell(cycle_start_strobe_n_i) && strobe_q |=> cycle_is_mem_o == ($past(mem_or_io_i) == MIO_MEMORY);
    endproperty
    a_mem_decode: assert property (p_mem_decode) else $error("memory cycle decode wrong");

    property p_wr_decode;
        @(posedge clk_i) disable iff (!reset_n_i)
        strobe_q && !cycle_start_strobe_n_i |=> cycle_is_write_o == $past(write_or_read_i);
    endproperty
    a_wr_decode: assert property (p_wr_decode) else $error("write decode wrong");

    property p_strap_tristate;
        @(posedge clk_i) disable iff (!reset_n_i)
        por_active |=> clock_freq_strap_oe_o == '0;
    endproperty
    a_strap_tristate: assert property (p_strap_tristate) else $error("strap pins driven in reset");

    property p_ras_drive;
        @(posedge clk_i) disable iff (!reset_n_i)
        !por_active ##1 !por_active |-> clock_freq_strap_oe_o == {STRAP_W{1'b1}};
    endproperty
    a_ras_drive: assert property (p_ras_drive) else $error("row strobes not driven");

    property p_strap_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        strap_done_q ##1 !por_active |-> $stable(strap_q) && $stable(alter_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after reset");

    property p_addr_dir;
        @(posedge clk_i) disable iff (!reset_n_i)
        local_addr_bus_oe_o == (owner_i == CLB_OWN_DMA) && (!local_addr_bus_oe_o || local_addr_bus_o == dma_addr_i);
    endproperty
    a_addr_dir: assert property (p_addr_dir) else $error("address direction wrong");

    property p_a26_cpu_in;
        @(posedge clk_i) disable iff (!reset_n_i)
        owner_i == CLB_OWN_CPU || !cpu_is_486_i |-> !addr_bit26_or_fpu_busy_oe_o;
    endproperty
    a_a26_cpu_in: assert property (p_a26_cpu_in) else $error("bit 26 driven when it must be input");
endmodule : clb_pin_logic

// file: dv/clb_cpu_model.sv
`timescale 1ns/1ps
module clb_cpu_model
    import clb_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Local bus side
    output logic strobe_n_o,
    output logic mio_o,
    output logic wr_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic a26_o
);
    initial begin
        strobe_n_o = 1'b1;
        mio_o = 1'b0;
        wr_o = 1'b0;
        addr_o = '0;
        a26_o = 1'b0;
    end

    // One strobe-low cycle, then at least one idle sample
    task automatic issue(input logic m, input logic w, input logic [ADDR_W-1:0] a, input logic a26);
        @(posedge clk_i);
        #1;
        strobe_n_o = 1'b0;
        mio_o = m;
        wr_o = w;
        addr_o = a;
        a26_o = a26;
        @(posedge clk_i);
        #1;
        strobe_n_o = 1'b1;
        // Qualifiers past the cycle no longer hold their value
        mio_o = ~m;
        wr_o = ~w;
        addr_o = ~a;
        a26_o = ~a26;
    endtask : issue
endmodule : clb_cpu_model

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import clb_pkg::*;
;
    logic clk_i = 1'b0, reset_n_i = 1'b0, power_ok_i = 1'b1, soft_reset_req_i = 1'b0, cpu_is_486_i = 1'b1;
    logic dma_addr26_i = 1'b0, mem_addr_bit9_i = 1'b0, alter_bit_out_i = 1'b0, busy_n = 1'b1, cd_drv = 1'b0;
    logic [ADDR_W-1:0] dma_addr_i = '0;
    logic [STRAP_W-1:0] strap_v = '0, row_strobe_n_req_i = '0, e;
    clb_owner_t owner_i = CLB_OWN_CPU;
    logic strobe_n, mio, wr, m_a26, cycle_start_o, cycle_is_mem_o, cycle_is_write_o, local_addr_bus_oe_o;
    logic addr_bit26_or_fpu_busy_i, addr_bit26_or_fpu_busy_o, addr_bit26_or_fpu_busy_oe_o, captured_addr26_o;
    logic fpu_busy_o, code_data_or_alter_bit_i, code_data_or_alter_bit_o, code_data_or_alter_bit_oe_o;
    logic alter_mode_o, code_data_o, processor_hard_reset_o, isa_reset_n_o, processor_soft_reset_o;
    clb_cyc_t cycle_type_o;
    logic [ADDR_W-1:0] m_addr, local_addr_bus_i, local_addr_bus_o, captured_addr_o;
    logic [STRAP_W-1:0] clock_freq_strap_i, clock_freq_strap_o, clock_freq_strap_oe_o, clock_freq_sel_o;
    logic [ADDR_W+2:0] exp_q[$], ex;
    int errors = 0, check_count = 0;

    // Pin levels from every driver
    assign local_addr_bus_i = local_addr_bus_oe_o ? local_addr_bus_o : m_addr;
    assign addr_bit26_or_fpu_busy_i = addr_bit26_or_fpu_busy_oe_o ? addr_bit26_or_fpu_busy_o :
                                      (cpu_is_486_i ? m_a26 : busy_n);
    assign clock_freq_strap_i = (clock_freq_strap_oe_o & clock_freq_strap_o) | (~clock_freq_strap_oe_o & strap_v);
    assign code_data_or_alter_bit_i = code_data_or_alter_bit_oe_o ? code_data_or_alter_bit_o : cd_drv;

    clb_cpu_model cpu (.clk_i, .strobe_n_o(strobe_n), .mio_o(mio), .wr_o(wr), .addr_o(m_addr), .a26_o(m_a26));

    clb_pin_logic DUT (.clk_i, .reset_n_i, .power_ok_i, .soft_reset_req_i, .cpu_is_486_i,
        .cycle_start_strobe_n_i(strobe_n), .mem_or_io_i(mio), .write_or_read_i(wr), .cycle_start_o, .cycle_is_mem_o,
        .cycle_is_write_o, .cycle_type_o, .owner_i, .local_addr_bus_i, .dma_addr_i, .local_addr_bus_o,
        .local_addr_bus_oe_o, .captured_addr_o, .addr_bit26_or_fpu_busy_i, .dma_addr26_i, .addr_bit26_or_fpu_busy_o,
        .addr_bit26_or_fpu_busy_oe_o, .captured_addr26_o, .fpu_busy_o, .clock_freq_strap_i, .row_strobe_n_req_i,
        .clock_freq_strap_o, .clock_freq_strap_oe_o, .clock_freq_sel_o, .mem_addr_bit9_i, .code_data_or_alter_bit_i,
        .alter_bit_out_i, .code_data_or_alter_bit_o, .code_data_or_alter_bit_oe_o, .alter_mode_o, .code_data_o,
        .processor_hard_reset_o, .isa_reset_n_o, .processor_soft_reset_o);

    initial begin
        forever #25 clk_i = ~clk_i;
    end

////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

////////////////////////////////////////////////////////////////
    task automatic power_up(input logic b9);
        int n;
        reset_n_i = 1'b0;
        power_ok_i = !b9;
        mem_addr_bit9_i = b9;
        strap_v = STRAP_W'($urandom);
        e = strap_v;
        tick(20);
        chk(processor_hard_reset_o, 1);
        chk(isa_reset_n_o, 0);
        reset_n_i = 1'b1;
        tick(1);
        chk(clock_freq_strap_oe_o, 0);
        // Power good arrives one cycle late in the second power-up
        power_ok_i = 1'b1;
        n = 0;
        while (processor_hard_reset_o !== 1'b0 && n < 60) begin
            tick(1);
            n++;
        end
        if (n == 60) begin
            errors++;
            results();
        end
        chk(n, RESET_HOLD_CYC + b9);
        chk(isa_reset_n_o, 1);
        tick(2);
        chk(clock_freq_strap_oe_o, 4'hF);
        chk(clock_freq_sel_o, e);
        chk(alter_mode_o, !b9);
        strap_v = ~e;
        row_strobe_n_req_i = STRAP_W'($urandom);
        cd_drv = 1'($urandom);
        alter_bit_out_i = 1'($urandom);
        tick(2);
        chk(clock_freq_sel_o, e);
        chk(clock_freq_strap_i, row_strobe_n_req_i);
        chk(code_data_or_alter_bit_oe_o, !b9);
        chk(code_data_o, b9 & cd_drv);
        chk(code_data_or_alter_bit_i, b9 ? cd_drv : alter_bit_out_i);
        $display("test power_up done");
    endtask : power_up

    // Back-to-back cycles; the monitor below compares each start
    task automatic bus_cycles(input int n);
        logic [ADDR_W-1:0] a;
        logic a26;
        for (int i = 0; i < n; i++) begin
            a = ADDR_W'($urandom);
            a26 = 1'($urandom);
            exp_q.push_back({i[1], i[0], a26, a});
            cpu.issue(i[1], i[0], a, a26);
        end
        tick(3);
        chk(exp_q.size(), 0);
        $display("test bus_cycles done");
    endtask : bus_cycles

    always @(negedge clk_i) begin
        if (cycle_start_o === 1'b1) begin
            ex = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            chk(cycle_is_mem_o, ex[ADDR_W+2]);
            chk(cycle_is_write_o, ex[ADDR_W+1]);
            chk(cycle_type_o, ex[ADDR_W+2:ADDR_W+1]);
            chk(captured_addr_o, ex[ADDR_W-1:0]);
            chk(captured_addr26_o, ex[ADDR_W] & cpu_is_486_i);
        end
    end

    task automatic owners();
        for (int k = 0; k < 6; k++) begin
            cpu_is_486_i = k[0];
            owner_i = clb_owner_t'(k >> 1);
            dma_addr_i = ADDR_W'($urandom);
            dma_addr26_i = 1'($urandom);
            busy_n = 1'($urandom);
            tick(1);
            chk(local_addr_bus_i, owner_i == CLB_OWN_DMA ? dma_addr_i : m_addr);
            chk(addr_bit26_or_fpu_busy_oe_o, k[0] && owner_i != CLB_OWN_CPU);
            chk(fpu_busy_o, !k[0] && !busy_n);
            if (k[0] && owner_i != CLB_OWN_CPU) begin
                chk(addr_bit26_or_fpu_busy_i, dma_addr26_i);
            end
        end
        owner_i = CLB_OWN_CPU;
        cpu_is_486_i = 1'b1;
        $display("test owners done");
    endtask : owners

    // A request still held inside the pulse must not stretch it
    task automatic soft_pulse();
        soft_reset_req_i = 1'b1;
        tick(1);
        chk(processor_soft_reset_o, 1);
        tick(1);
        chk(processor_soft_reset_o, 1);
        chk(processor_hard_reset_o, 0);
        soft_reset_req_i = 1'b0;
        tick(1);
        chk(processor_soft_reset_o, 0);
        $display("test soft_pulse done");
    endtask : soft_pulse

    initial begin
        void'($urandom(32'h6ae88347));
        power_up(1'b0);
        bus_cycles(8);
        owners();
        soft_pulse();
        power_up(1'b1);
        cpu_is_486_i = 1'b0;
        bus_cycles(4);
        results();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        results();
    end
endmodule : tb_top
